// File: pmta_top.sv
// Program memory table access: pointer, latch, control and sequencer
// Behaviour
// - read start ignored when either select set
// - eight-bit table latch in register space
// - latch carries bytes both ways
// - pointer selects one program memory byte
// - upper, high, low bytes form pointer
// - low 21 bits address program space
// - top bit redirects table fetches to ID/configuration space; writes and erases use the space select instead
// - auto update changes low 21 bits only
// - keep, post-inc, post-dec, pre-inc modes
// - table fetch uses all 22 bits
// - erase ignores pointer bits five to zero
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/1ns
`include "pmta_cfg.svh"

module pmta_top
	import pmta_pkg::*;
#(
	parameter int HOLD_AW = 5 // Holding buffer index width
)
(
	sys_clk,
	rst,
	ce,
	reg_addr,
	reg_wdata,
	reg_wr,
	reg_rd,
	reg_rdata,
	tbl_valid,
	tbl_store,
	tbl_mode,
	tbl_ready,
	tbl_done,
	nvm_req,
	nvm_op,
	nvm_addr,
	nvm_cfg_space,
	nvm_flash,
	nvm_wdata,
	nvm_done,
	nvm_rdata,
	hold_idx,
	hold_data,
	irq
);
	input  wire logic                    sys_clk;       // System clock
	input  wire logic                    rst;           // Sync reset, high
	input  wire logic                    ce;            // Clock enable
	input  wire logic [`PMTA_ADDR_W-1:0] reg_addr;      // Register index
	input  wire logic [`PMTA_DATA_W-1:0] reg_wdata;     // Write data
	input  wire logic                    reg_wr;        // Write strobe
	input  wire logic                    reg_rd;        // Read strobe
	output logic      [`PMTA_DATA_W-1:0] reg_rdata;     // Read data
	input  wire logic                    tbl_valid;     // Table instruction
	input  wire logic                    tbl_store;     // 1 store, 0 fetch
	input  wire logic [1:0]              tbl_mode;      // Pointer mode
	output logic                         tbl_ready;     // Can take one
	output logic                         tbl_done;      // Instruction done
	output logic                         nvm_req;       // Memory op pulse
	output logic      [1:0]              nvm_op;        // Memory op code
	output logic      [`PMTA_PTR_W-1:0]  nvm_addr;      // Memory address
	output logic                         nvm_cfg_space; // Config space
	output logic                         nvm_flash;     // Flash, not EEPROM
	output logic      [`PMTA_DATA_W-1:0] nvm_wdata;     // EEPROM write byte
	input  wire logic                    nvm_done;      // Op finished
	input  wire logic [`PMTA_DATA_W-1:0] nvm_rdata;     // Read byte
	input  wire logic [HOLD_AW-1:0]      hold_idx;      // Buffer read index
	output logic      [`PMTA_DATA_W-1:0] hold_data;     // Buffer read byte
	output logic                         irq;           // Interrupt level

	// Pointer, latch and control state
	logic [`PMTA_PTR_W-1:0]  ptr_r;      // Table pointer, upper byte first
	logic [`PMTA_PTR_W-1:0]  ptr_nxt;    // Next pointer
	logic [`PMTA_DATA_W-1:0] latch_r;    // Table latch
	logic [`PMTA_DATA_W-1:0] latch_nxt;  // Next latch
	logic                    memsel_r;   // 1 flash, 0 EEPROM
	logic                    memsel_nxt; // Next memory select
	logic                    space_r;    // Configuration space select
	logic                    space_nxt;  // Next space select
	logic                    erase_r;    // Erase instead of write
	logic                    erase_nxt;  // Next erase select
	logic                    fault_r;    // Program fault flag
	logic                    fault_nxt;  // Next fault flag
	logic                    unlock_r;   // Program unlock
	logic                    unlock_nxt; // Next unlock
	logic                    wr_r;       // Write start, high while busy
	logic                    wr_nxt;     // Next write start
	logic                    rd_r;       // EEPROM read start, high while busy
	logic                    rd_nxt;     // Next read start
	pmta_state_e             state_r;    // Sequencer state
	pmta_state_e             state_nxt;  // Next state

	// Memory request and instruction outputs
	logic                    req_r;      // Request pulse
	logic                    req_nxt;    // Next request
	logic [1:0]              op_r;       // Operation code
	logic [1:0]              op_nxt;     // Next operation code
	logic [`PMTA_PTR_W-1:0]  addr_r;     // Request address
	logic [`PMTA_PTR_W-1:0]  addr_nxt;   // Next address
	logic                    cfg_r;      // Configuration space target
	logic                    cfg_nxt;    // Next space target
	logic                    flash_r;    // Flash target
	logic                    flash_nxt;  // Next flash target
	logic                    done_r;     // Instruction done pulse
	logic                    done_nxt;   // Next done

	// Interrupt and read-back state
	logic [`PMTA_IRQ_W-1:0]  stat_r;     // Sticky status bits
	logic [`PMTA_IRQ_W-1:0]  stat_nxt;   // Next status
	logic [`PMTA_IRQ_W-1:0]  mask_r;     // Interrupt mask
	logic [`PMTA_IRQ_W-1:0]  mask_nxt;   // Next mask
	logic [`PMTA_DATA_W-1:0] rdata_r;    // Read data register
	logic [`PMTA_DATA_W-1:0] rdata_nxt;  // Next read data
	logic                    irq_r;      // Interrupt level register
	logic                    irq_nxt;    // Next interrupt level
	logic [`PMTA_DATA_W-1:0] ctrl_rd;    // Control register image

	// Decodes and events
	logic                    take;       // Table instruction taken
	logic                    hold_wr;    // Store into holding buffer
	logic                    ctrl_wr;    // Control register write
	logic                    wr_go;      // Write or erase launch
	logic                    ee_rd_go;   // EEPROM read launch
	logic                    cut;        // Reset lands in a program cycle
	logic                    ev_wrdone;  // Program cycle finished
	logic                    ev_rddone;  // Read finished
	logic                    ev_fault;   // Program cycle cut by reset
	logic [`PMTA_PTR_W-1:0]  ptr_use;    // Address of this access
	logic [`PMTA_PTR_W-1:0]  ptr_after;  // Pointer after this access
	logic [`PMTA_PTR_W-1:0]  erase_addr; // Block aligned erase address

	// Pointer stepping, low part only
	pmta_ptr_step u_step
	(
		.ptr_in    (ptr_r),
		.mode      (tbl_mode),
		.ptr_use   (ptr_use),
		.ptr_after (ptr_after)
	);

	// Holding buffer for stored bytes
	pmta_hold_buf
	#(
		.AW (HOLD_AW),
		.DW (`PMTA_DATA_W)
	)
	u_hold
	(
		.sys_clk (sys_clk),
		.ce      (ce),
		.wr_en   (hold_wr),
		.wr_idx  (ptr_use[HOLD_AW-1:0]),
		.wr_data (latch_r),
		.rd_idx  (hold_idx),
		.rd_data (hold_data)
	);

	// Handshake and launch decodes
	assign tbl_ready  = (state_r == PMTA_IDLE);
	assign take       = tbl_valid && tbl_ready;
	assign hold_wr    = take && tbl_store;
	assign ctrl_wr    = reg_wr && (reg_addr == `PMTA_OFS_CTRL);
	// Write needs the unlock already set
	assign wr_go      = ctrl_wr && reg_wdata[`PMTA_CTRL_WR] && unlock_r;
	// Read start refused with either select set
	assign ee_rd_go   = ctrl_wr && reg_wdata[`PMTA_CTRL_RD]
		&& !reg_wdata[`PMTA_CTRL_MEMSEL] && !reg_wdata[`PMTA_CTRL_SPACE];
	assign cut        = rst && (state_r == PMTA_PROG);
	// Erase drops the in-block offset
	assign erase_addr = {ptr_r[`PMTA_PTR_W-1:`PMTA_ERASE_LSB], {`PMTA_ERASE_LSB{1'h0}}};

	// Outputs straight from registers
	assign tbl_done      = done_r;
	assign nvm_req       = req_r;
	assign nvm_op        = op_r;
	assign nvm_addr      = addr_r;
	assign nvm_cfg_space = cfg_r;
	assign nvm_flash     = flash_r;
	assign nvm_wdata     = latch_r;
	assign reg_rdata     = rdata_r;
	assign irq           = irq_r;

	// Next pointer, latch, control and sequencer state
	always_comb
	begin
		ptr_nxt    = ptr_r;
		latch_nxt  = latch_r;
		memsel_nxt = memsel_r;
		space_nxt  = space_r;
		erase_nxt  = erase_r;
		fault_nxt  = fault_r;
		unlock_nxt = unlock_r;
		wr_nxt     = wr_r;
		rd_nxt     = rd_r;
		state_nxt  = state_r;
		req_nxt    = 1'h0;
		op_nxt     = op_r;
		addr_nxt   = addr_r;
		cfg_nxt    = cfg_r;
		flash_nxt  = flash_r;
		done_nxt   = 1'h0;
		ev_wrdone  = 1'h0;
		ev_rddone  = 1'h0;
		ev_fault   = 1'h0;
		// Software writes; start bits only through launches
		if (reg_wr)
		begin
			case (reg_addr)
				`PMTA_OFS_PTR_LOW:  ptr_nxt[`PMTA_DATA_W-1:0] = reg_wdata;
				`PMTA_OFS_PTR_HIGH: ptr_nxt[`PMTA_PTR_W-`PMTA_UP_W-1:`PMTA_DATA_W] = reg_wdata;
				`PMTA_OFS_PTR_UP:
					ptr_nxt[`PMTA_PTR_W-1:`PMTA_PTR_W-`PMTA_UP_W] = reg_wdata[`PMTA_UP_W-1:0];
				`PMTA_OFS_LATCH:    latch_nxt = reg_wdata;
				`PMTA_OFS_CTRL:
				begin
					memsel_nxt = reg_wdata[`PMTA_CTRL_MEMSEL];
					space_nxt  = reg_wdata[`PMTA_CTRL_SPACE];
					erase_nxt  = reg_wdata[`PMTA_CTRL_ERASE];
					fault_nxt  = reg_wdata[`PMTA_CTRL_FAULT];
					unlock_nxt = reg_wdata[`PMTA_CTRL_UNLOCK];
				end
				default: ;
			endcase
		end
		// Sequencer; a table instruction wins over a launch
		case (state_r)
			PMTA_IDLE:
			begin
				if (hold_wr)
				begin
					ptr_nxt  = ptr_after;
					done_nxt = 1'h1;
				end
				else if (take)
				begin
					ptr_nxt   = ptr_after;
					req_nxt   = 1'h1;
					op_nxt    = `PMTA_OP_READ;
					addr_nxt  = ptr_use;
					cfg_nxt   = ptr_use[`PMTA_PTR_TOP];
					flash_nxt = 1'h1;
					state_nxt = PMTA_FETCH;
				end
				else if (wr_go)
				begin
					wr_nxt    = 1'h1;
					req_nxt   = 1'h1;
					op_nxt    = reg_wdata[`PMTA_CTRL_ERASE] ? `PMTA_OP_ERASE : `PMTA_OP_WRITE;
					addr_nxt  = reg_wdata[`PMTA_CTRL_ERASE] ? erase_addr : ptr_r;
					flash_nxt = reg_wdata[`PMTA_CTRL_MEMSEL];
					cfg_nxt   = reg_wdata[`PMTA_CTRL_SPACE];
					state_nxt = PMTA_PROG;
				end
				else if (ee_rd_go)
				begin
					rd_nxt    = 1'h1;
					req_nxt   = 1'h1;
					op_nxt    = `PMTA_OP_READ;
					addr_nxt  = ptr_r;
					cfg_nxt   = 1'h0;
					flash_nxt = 1'h0;
					state_nxt = PMTA_EEREAD;
				end
			end
			// Fetched byte goes into the latch
			PMTA_FETCH:
			begin
				if (nvm_done)
				begin
					latch_nxt = nvm_rdata;
					done_nxt  = 1'h1;
					ev_rddone = 1'h1;
					state_nxt = PMTA_IDLE;
				end
			end
			// EEPROM byte also lands in the latch
			PMTA_EEREAD:
			begin
				if (nvm_done)
				begin
					latch_nxt = nvm_rdata;
					rd_nxt    = 1'h0;
					ev_rddone = 1'h1;
					state_nxt = PMTA_IDLE;
				end
			end
			// Write or erase runs until the memory answers
			PMTA_PROG:
			begin
				if (nvm_done)
				begin
					wr_nxt    = 1'h0;
					ev_wrdone = 1'h1;
					state_nxt = PMTA_IDLE;
				end
			end
			default: state_nxt = PMTA_IDLE;
		endcase
		// Reset; a cut program cycle leaves its trace
		if (rst)
		begin
			ptr_nxt    = `PMTA_RST_PTR;
			latch_nxt  = `PMTA_RST_BYTE;
			erase_nxt  = 1'h0;
			unlock_nxt = 1'h0;
			wr_nxt     = 1'h0;
			rd_nxt     = 1'h0;
			state_nxt  = PMTA_IDLE;
			req_nxt    = 1'h0;
			op_nxt     = `PMTA_OP_READ;
			addr_nxt   = `PMTA_RST_PTR;
			cfg_nxt    = 1'h0;
			flash_nxt  = 1'h0;
			done_nxt   = 1'h0;
			ev_wrdone  = 1'h0;
			ev_rddone  = 1'h0;
			// Fault survives reset; unknown until software clears it
			fault_nxt  = fault_r | cut;
			memsel_nxt = cut ? memsel_r : 1'h0;
			space_nxt  = cut ? space_r : 1'h0;
			ev_fault   = cut;
		end
	end

	// Register the pointer, latch, control and sequencer state
	always_ff @(posedge sys_clk)
	begin
		if (ce)
		begin
			ptr_r    <= ptr_nxt;
			latch_r  <= latch_nxt;
			memsel_r <= memsel_nxt;
			space_r  <= space_nxt;
			erase_r  <= erase_nxt;
			fault_r  <= fault_nxt;
			unlock_r <= unlock_nxt;
			wr_r     <= wr_nxt;
			rd_r     <= rd_nxt;
			state_r  <= state_nxt;
			req_r    <= req_nxt;
			op_r     <= op_nxt;
			addr_r   <= addr_nxt;
			cfg_r    <= cfg_nxt;
			flash_r  <= flash_nxt;
			done_r   <= done_nxt;
		end
	end

	// Next status, mask, read data and interrupt
	always_comb
	begin
		stat_nxt  = stat_r;
		mask_nxt  = mask_r;
		rdata_nxt = `PMTA_RST_BYTE;
		ctrl_rd   = `PMTA_RST_BYTE;
		ctrl_rd[`PMTA_CTRL_MEMSEL] = memsel_r;
		ctrl_rd[`PMTA_CTRL_SPACE]  = space_r;
		ctrl_rd[`PMTA_CTRL_ERASE]  = erase_r;
		ctrl_rd[`PMTA_CTRL_FAULT]  = fault_r;
		ctrl_rd[`PMTA_CTRL_UNLOCK] = unlock_r;
		ctrl_rd[`PMTA_CTRL_WR]     = wr_r;
		ctrl_rd[`PMTA_CTRL_RD]     = rd_r;
		// Reading status clears it, a new event wins
		if (reg_rd && (reg_addr == `PMTA_OFS_IRQ_STAT))
			stat_nxt = {`PMTA_IRQ_W{1'h0}};
		if (ev_wrdone)
			stat_nxt[`PMTA_IRQ_WRDONE] = 1'h1;
		if (ev_rddone)
			stat_nxt[`PMTA_IRQ_RDDONE] = 1'h1;
		if (reg_wr && (reg_addr == `PMTA_OFS_IRQ_MASK))
			mask_nxt = reg_wdata[`PMTA_IRQ_W-1:0];
		// Read data stand only in the cycle after the strobe
		if (reg_rd)
		begin
			case (reg_addr)
				`PMTA_OFS_PTR_LOW:  rdata_nxt = ptr_r[`PMTA_DATA_W-1:0];
				`PMTA_OFS_PTR_HIGH: rdata_nxt = ptr_r[`PMTA_PTR_W-`PMTA_UP_W-1:`PMTA_DATA_W];
				`PMTA_OFS_PTR_UP:
					rdata_nxt = {{(`PMTA_DATA_W-`PMTA_UP_W){1'h0}},
						ptr_r[`PMTA_PTR_W-1:`PMTA_PTR_W-`PMTA_UP_W]};
				`PMTA_OFS_LATCH:    rdata_nxt = latch_r;
				`PMTA_OFS_CTRL:     rdata_nxt = ctrl_rd;
				`PMTA_OFS_IRQ_STAT: rdata_nxt = {{(`PMTA_DATA_W-`PMTA_IRQ_W){1'h0}}, stat_r};
				`PMTA_OFS_IRQ_MASK: rdata_nxt = {{(`PMTA_DATA_W-`PMTA_IRQ_W){1'h0}}, mask_r};
				default:            rdata_nxt = `PMTA_RST_BYTE;
			endcase
		end
		// Level follows the status as it is stored
		irq_nxt = |(stat_nxt & mask_nxt);
		// Reset keeps only the cut-write event
		if (rst)
		begin
			stat_nxt = {`PMTA_IRQ_W{1'h0}};
			stat_nxt[`PMTA_IRQ_FAULT] = ev_fault;
			mask_nxt  = {`PMTA_IRQ_W{1'h0}};
			rdata_nxt = `PMTA_RST_BYTE;
			irq_nxt   = 1'h0;
		end
	end

	// Register status, mask, read data and interrupt
	always_ff @(posedge sys_clk)
	begin
		if (ce)
		begin
			stat_r  <= stat_nxt;
			mask_r  <= mask_nxt;
			rdata_r <= rdata_nxt;
			irq_r   <= irq_nxt;
		end
	end

endmodule

// File: pmta_cfg.svh
// Constants for the program memory table access block
`ifndef PMTA_CFG_SVH
`define PMTA_CFG_SVH

// Register index width and data width
`define PMTA_ADDR_W       3
`define PMTA_DATA_W       8

// Register offsets
`define PMTA_OFS_PTR_LOW  3'h0
`define PMTA_OFS_PTR_HIGH 3'h1
`define PMTA_OFS_PTR_UP   3'h2
`define PMTA_OFS_LATCH    3'h3
`define PMTA_OFS_CTRL     3'h4
`define PMTA_OFS_IRQ_STAT 3'h5
`define PMTA_OFS_IRQ_MASK 3'h6

// Control register bit positions
`define PMTA_CTRL_MEMSEL  7
`define PMTA_CTRL_SPACE   6
`define PMTA_CTRL_ERASE   4
`define PMTA_CTRL_FAULT   3
`define PMTA_CTRL_UNLOCK  2
`define PMTA_CTRL_WR      1
`define PMTA_CTRL_RD      0

// Interrupt status bit positions
`define PMTA_IRQ_WRDONE   0
`define PMTA_IRQ_RDDONE   1
`define PMTA_IRQ_FAULT    2
`define PMTA_IRQ_W        3

// Pointer geometry
`define PMTA_PTR_W        22
`define PMTA_PTR_LOW_W    21
`define PMTA_PTR_TOP      21
`define PMTA_ERASE_LSB    6
`define PMTA_UP_W         6

// Table pointer update modes
`define PMTA_MODE_KEEP    2'h0
`define PMTA_MODE_POSTINC 2'h1
`define PMTA_MODE_POSTDEC 2'h2
`define PMTA_MODE_PREINC  2'h3

// Memory operation codes
`define PMTA_OP_READ      2'h0
`define PMTA_OP_WRITE     2'h1
`define PMTA_OP_ERASE     2'h2

// Reset values
`define PMTA_RST_BYTE     8'h00
`define PMTA_RST_PTR      22'h00_0000

`endif

// File: pmta_pkg.sv
// Types shared by the program memory table access block
package pmta_pkg;

	// Sequencer states
	typedef enum logic [1:0]
	{
		PMTA_IDLE,
		PMTA_FETCH,
		PMTA_EEREAD,
		PMTA_PROG
	} pmta_state_e;

	// Byte data type
	typedef logic [7:0] pmta_byte_t;

endpackage

// File: pmta_ptr_step.sv
// Table pointer pre and post adjustment for table instructions
`timescale 1ns/1ns
`include "pmta_cfg.svh"

module pmta_ptr_step
	import pmta_pkg::*;
(
	ptr_in,
	mode,
	ptr_use,
	ptr_after
);
	input  wire logic [`PMTA_PTR_W-1:0] ptr_in;    // Current pointer
	input  wire logic [1:0]             mode;      // Update mode
	output logic      [`PMTA_PTR_W-1:0] ptr_use;   // Address for access
	output logic      [`PMTA_PTR_W-1:0] ptr_after; // Pointer after access

	logic [`PMTA_PTR_LOW_W-1:0] low_inc; // Low part plus one
	logic [`PMTA_PTR_LOW_W-1:0] low_dec; // Low part minus one
	logic                       top;     // Space bit, never stepped

	// Step only the low part, top bit carried through
	always_comb
	begin
		top     = ptr_in[`PMTA_PTR_TOP];
		low_inc = ptr_in[`PMTA_PTR_LOW_W-1:0] + 21'h1;
		low_dec = ptr_in[`PMTA_PTR_LOW_W-1:0] - 21'h1;
		ptr_use   = ptr_in;
		ptr_after = ptr_in;
		case (mode)
			`PMTA_MODE_POSTINC: ptr_after = {top, low_inc};
			`PMTA_MODE_POSTDEC: ptr_after = {top, low_dec};
			`PMTA_MODE_PREINC:
			begin
				ptr_use   = {top, low_inc};
				ptr_after = {top, low_inc};
			end
			default: ptr_after = ptr_in;
		endcase
	end

endmodule

// File: pmta_hold_buf.sv
// Holding buffer that collects table store bytes before programming
`timescale 1ns/1ns
`include "pmta_cfg.svh"

module pmta_hold_buf
	import pmta_pkg::*;
#(
	parameter int AW = 5, // Index width
	parameter int DW = 8  // Byte width
)
(
	sys_clk,
	ce,
	wr_en,
	wr_idx,
	wr_data,
	rd_idx,
	rd_data
);
	input  wire logic          sys_clk; // System clock
	input  wire logic          ce;      // Clock enable
	input  wire logic          wr_en;   // Write strobe
	input  wire logic [AW-1:0] wr_idx;  // Write index
	input  wire logic [DW-1:0] wr_data; // Write byte
	input  wire logic [AW-1:0] rd_idx;  // Read index
	output logic      [DW-1:0] rd_data; // Registered read byte

	logic [DW-1:0] mem [0:(1<<AW)-1]; // Storage
	logic [DW-1:0] rd_nxt;            // Next read byte

	// Read look-up
	always_comb
	begin
		rd_nxt = mem[rd_idx];
	end

	// Storage and read register
	always_ff @(posedge sys_clk)
	begin
		if (ce)
		begin
			if (wr_en)
				mem[wr_idx] <= wr_data;
			rd_data <= rd_nxt;
		end
	end

endmodule

// File: pmta_top_assertions.sv
// Concurrent checks on the table access block ports
`timescale 1ns/1ns
`include "pmta_cfg.svh"
module pmta_top_checker
	import pmta_pkg::*;
(
	sys_clk,
	rst,
	tbl_valid,
	tbl_store,
	tbl_ready,
	tbl_done,
	nvm_req,
	nvm_op,
	nvm_addr,
	nvm_cfg_space,
	nvm_flash,
	irq
);
	input wire logic                   sys_clk;       // Clock
	input wire logic                   rst;           // Reset
	input wire logic                   tbl_valid;     // Instruction
	input wire logic                   tbl_store;     // Store or fetch
	input wire logic                   tbl_ready;     // Can take one
	input wire logic                   tbl_done;      // Finished
	input wire logic                   nvm_req;       // Op pulse
	input wire logic [1:0]             nvm_op;        // Op code
	input wire logic [`PMTA_PTR_W-1:0] nvm_addr;      // Address
	input wire logic                   nvm_cfg_space; // Config space
	input wire logic                   nvm_flash;     // Flash target
	input wire logic                   irq;           // Interrupt
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	// A fetch taken, then a memory read
	sequence s_fetch_taken;
		tbl_valid && tbl_ready && !tbl_store;
	endsequence
	sequence s_flash_read;
		nvm_req && nvm_op == `PMTA_OP_READ && nvm_flash;
	endsequence
	a_fetch_goes_out: assert property (s_fetch_taken |-> ##[0:8] nvm_req)
		else $error("fetch produced no memory read");
	a_req_one_pulse: assert property (nvm_req |=> !nvm_req)
		else $error("memory request longer than one cycle");
	a_top_bit_space: assert property (s_flash_read |-> nvm_cfg_space == nvm_addr[21])
		else $error("top pointer bit not steering space");
	a_ee_read_plain: assert property (nvm_req && !nvm_flash && nvm_op == `PMTA_OP_READ
		|-> !nvm_cfg_space)
		else $error("EEPROM read with a select bit set");
	a_erase_block: assert property (nvm_req && nvm_op == `PMTA_OP_ERASE
		|-> nvm_addr[5:0] == 6'h00)
		else $error("erase address not block aligned");
	a_fetch_done: assert property (s_fetch_taken |-> ##[1:12] tbl_done)
		else $error("fetch never finished");
	a_no_stray_done: assert property (tbl_done |=> !tbl_done)
		else $error("done longer than one cycle");
	a_irq_quiet: assert property ($fell(rst) |-> !irq)
		else $error("interrupt raised out of reset");
endmodule
bind pmta_top pmta_top_checker u_chk (.*);

// File: pmta_mem_model.sv
// Memory model behind the block: answers each request after two cycles
`timescale 1ns/1ns
module pmta_mem_model
(
	sys_clk,
	nvm_req,
	nvm_addr,
	nvm_done,
	nvm_rdata
);
	input  wire logic        sys_clk;           // Clock
	input  wire logic        nvm_req;           // Request pulse
	input  wire logic [21:0] nvm_addr;          // Byte address
	output logic             nvm_done = 1'b0;   // Finish pulse
	output logic      [7:0]  nvm_rdata = 8'h00; // Read byte
	logic             [7:0]  a_lo;              // Captured address byte
	// Idle data toggles so stale bytes never look valid
	always @(posedge sys_clk)
	begin
		nvm_done <= 1'b0;
		nvm_rdata <= ~nvm_rdata;
		if (nvm_req)
		begin
			a_lo = nvm_addr[7:0];
			repeat (2) @(posedge sys_clk);
			nvm_done <= 1'b1;
			nvm_rdata <= a_lo ^ 8'h5A;
		end
	end
endmodule

// File: test_program_memory_table_access.sv
// Self-checking bench for the table access block
`timescale 1ns/1ns
`include "pmta_cfg.svh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module test_program_memory_table_access
	import pmta_pkg::*;
;
	logic sys_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, tbl_valid = 0, tbl_store = 0;
	logic [2:0] reg_addr = 0;          // Register index
	logic [7:0] reg_wdata = 0, rdat;   // Bus data
	logic [1:0] tbl_mode = 0;          // Pointer mode
	logic tbl_ready, tbl_done, nvm_req, nvm_cfg_space, nvm_flash, nvm_done, irq;
	logic [1:0] nvm_op;                // Op code
	logic [21:0] nvm_addr;             // Memory address
	logic [7:0] nvm_wdata, nvm_rdata, reg_rdata, hold_data;
	int n_fail = 0, n_compared = 0, i, j;
	pmta_top dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.tbl_valid(tbl_valid), .tbl_store(tbl_store), .tbl_mode(tbl_mode),
		.tbl_ready(tbl_ready), .tbl_done(tbl_done), .nvm_req(nvm_req), .nvm_op(nvm_op),
		.nvm_addr(nvm_addr), .nvm_cfg_space(nvm_cfg_space), .nvm_flash(nvm_flash),
		.nvm_wdata(nvm_wdata), .nvm_done(nvm_done), .nvm_rdata(nvm_rdata),
		.hold_idx(5'h00), .hold_data(hold_data), .irq(irq));
	pmta_mem_model mem (.sys_clk(sys_clk), .nvm_req(nvm_req), .nvm_addr(nvm_addr),
		.nvm_done(nvm_done), .nvm_rdata(nvm_rdata));
	initial forever #4 sys_clk = ~sys_clk;
	// Verdict and stop
	task end_of_test();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// One-cycle bus accesses
	task wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge sys_clk) reg_wr <= 0;
	endtask
	task rd(input logic [2:0] a);
		@(posedge sys_clk) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge sys_clk) reg_rd <= 0;
		#1 rdat = reg_rdata;
	endtask
	// One table instruction: offer, wait until taken, wait until done
	task tbl_go(input logic st, input logic [1:0] m);
		@(posedge sys_clk) {tbl_valid, tbl_store, tbl_mode} <= {1'b1, st, m};
		for (i = 0; i < 50; i++)
		begin
			@(posedge sys_clk);
			if (tbl_ready === 1'b1) break;
		end
		tbl_valid <= 0;
		for (j = 0; j < 50; j++)
		begin
			@(posedge sys_clk);
			if (tbl_done === 1'b1) break;
		end
		if (i == 50 || j == 50) begin n_fail++; end_of_test(); end
	endtask
	// Poll a control bit until the block clears it
	task wait_clr(input int b);
		for (j = 0; j < 50; j++)
		begin
			rd(`PMTA_OFS_CTRL);
			if (rdat[b] === 1'b0) break;
		end
		if (j == 50) begin n_fail++; end_of_test(); end
	endtask
	// Fetch at the top of the configuration space with post-increment
	task t_fetch();
		wr(`PMTA_OFS_PTR_UP, 8'h3F);
		wr(`PMTA_OFS_PTR_HIGH, 8'hFF);
		wr(`PMTA_OFS_PTR_LOW, 8'hFF);
		tbl_go(1'b0, `PMTA_MODE_POSTINC);
		rd(`PMTA_OFS_LATCH); `CHK("latch", 8'hA5, rdat)
		rd(`PMTA_OFS_PTR_UP); `CHK("upper", 8'h20, rdat)
		rd(`PMTA_OFS_PTR_LOW); `CHK("low", 8'h00, rdat)
		`CHK("irq set", 1'b1, irq)
		rd(`PMTA_OFS_IRQ_STAT); `CHK("status", 8'h02, rdat)
		rd(`PMTA_OFS_IRQ_STAT); `CHK("status clear", 8'h00, rdat)
		`CHK("irq clear", 1'b0, irq)
	endtask
	// Store with keep, then pre-increment and post-decrement fetches
	task t_modes();
		wr(`PMTA_OFS_LATCH, 8'h3C);
		tbl_go(1'b1, `PMTA_MODE_KEEP);
		@(posedge sys_clk);
		`CHK("hold", 8'h3C, hold_data)
		rd(`PMTA_OFS_PTR_LOW); `CHK("keep", 8'h00, rdat)
		tbl_go(1'b0, `PMTA_MODE_PREINC);
		rd(`PMTA_OFS_PTR_LOW); `CHK("preinc", 8'h01, rdat)
		rd(`PMTA_OFS_LATCH); `CHK("preinc latch", 8'h5B, rdat)
		tbl_go(1'b0, `PMTA_MODE_POSTDEC);
		rd(`PMTA_OFS_PTR_LOW); `CHK("postdec", 8'h00, rdat)
	endtask
	// EEPROM read through the control register
	task t_ee();
		rd(`PMTA_OFS_IRQ_STAT); `CHK("fetch status", 8'h02, rdat)
		wr(`PMTA_OFS_CTRL, 8'h01);
		wait_clr(`PMTA_CTRL_RD);
		`CHK("rd cleared", 1'b0, rdat[0])
		rd(`PMTA_OFS_LATCH); `CHK("ee latch", 8'h5A, rdat)
		rd(`PMTA_OFS_IRQ_STAT); `CHK("ee status", 8'h02, rdat)
	endtask
	// Erase to completion, then one cut short by a reset
	task t_erase();
		wr(`PMTA_OFS_PTR_LOW, 8'h3F);
		wr(`PMTA_OFS_CTRL, 8'h84);
		wr(`PMTA_OFS_CTRL, 8'h96);
		wait_clr(`PMTA_CTRL_WR);
		rd(`PMTA_OFS_IRQ_STAT); `CHK("erase status", 8'h01, rdat)
		wr(`PMTA_OFS_CTRL, 8'h96);
		@(posedge sys_clk) rst <= 1;
		@(posedge sys_clk) rst <= 0;
		rd(`PMTA_OFS_CTRL); `CHK("cut ctrl", 8'h88, rdat)
		rd(`PMTA_OFS_IRQ_STAT); `CHK("cut status", 8'h04, rdat)
	endtask
	// Read start refused while a select bit is set
	task t_rd_block();
		wr(`PMTA_OFS_CTRL, 8'h81);
		rd(`PMTA_OFS_CTRL); `CHK("rd start", 1'b0, rdat[0])
		`CHK("memsel", 1'b1, rdat[7])
	endtask
	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst <= 0;
		wr(`PMTA_OFS_IRQ_MASK, 8'h0F);
		t_fetch();
		t_modes();
		t_ee();
		t_rd_block();
		t_erase();
		end_of_test();
	end
endmodule
